// >>> rtl/rtc_ctrl_stat.sv
// control and status registers, square-wave and alarm interrupt output
`timescale 1ns/100ps
`default_nettype none
module rtc_ctrl_stat #(
  parameter int unsigned DIV_BITS = rtc_pkg::DIV_BITS
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire rtc_pkg::rtc_req_type reg_req,
  input  wire rtc_pkg::rtc_evt_type evt,
  input  wire logic                 osc_pin,
  input  wire logic                 osc_halt_pin,
  output var  logic [7:0]           rd_data_q,
  output var  logic                 wave_or_irq_out,
  output var  logic                 alarm_irq_out_n,
  output var  logic                 cal_tick_q,
  output var  logic                 cal_clear_q,
  output var  logic                 cal_hold_q
);

  logic                  rst_s1_q;
  logic                  rst_sync_n;
  logic                  osc_s1_q;
  logic                  osc_s2_q;
  logic                  halt_s1_q;
  logic                  halt_s2_q;
  rtc_pkg::rtc_ctrl_type ctrl_q;
  rtc_pkg::rtc_stat_type stat_q;
  logic                  ctrl_wr;
  logic                  stat_wr;
  logic                  cal_wr;
  logic                  start_req;
  logic                  wave;
  logic                  sec_tick;
  logic                  a1_set;
  logic                  a2_set;
  logic                  wr_free;
  logic                  alarm_on;
  logic                  alarm_irq_out_on;

  initial begin
    if (DIV_BITS < rtc_pkg::DIV_BITS) begin
      $error("divider must span at least one second");
    end
  end

  // register address match on a write
  function automatic logic wr_hit(input rtc_pkg::rtc_req_type r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  // read mux, unused bits and unmapped offsets give zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input rtc_pkg::rtc_ctrl_type c,
                                        input rtc_pkg::rtc_stat_type s);
    if (a == rtc_pkg::CTRL_ADDR) begin
      rd_mux = c;
    end else if (a == rtc_pkg::STAT_ADDR) begin
      rd_mux = s;
    end else begin
      rd_mux = 8'h00;
    end
  endfunction : rd_mux

  // reset release synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_q   <= 1'b1;
      rst_sync_n <= rst_s1_q;
    end
  end

  // pin synchronisers
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      osc_s1_q  <= 1'b0;
      osc_s2_q  <= 1'b0;
      halt_s1_q <= 1'b0;
      halt_s2_q <= 1'b0;
    end else begin
      osc_s1_q  <= osc_pin;
      osc_s2_q  <= osc_s1_q;
      halt_s1_q <= osc_halt_pin;
      halt_s2_q <= halt_s1_q;
    end
  end

  assign ctrl_wr   = wr_hit(reg_req, rtc_pkg::CTRL_ADDR);
  assign stat_wr   = wr_hit(reg_req, rtc_pkg::STAT_ADDR);
  assign cal_wr    = reg_req.wr && (reg_req.addr <= rtc_pkg::CAL_LAST_ADDR);
  assign start_req = ctrl_wr && ctrl_q.hold_to_set_flag &&
                     !reg_req.wdata[rtc_pkg::HOLD_BIT];
  assign wr_free   = reg_req.wdata[rtc_pkg::FREE_BIT];

  // square wave and seconds prescaler
  rtc_wave_div #(
    .DIV_BITS (DIV_BITS)
  ) u_div (
    .clk        (clk),
    .rst_n      (rst_sync_n),
    .osc_lvl    (osc_s2_q),
    .clear      (cal_clear_q),
    .rate       ({ctrl_q.rate_select_high, ctrl_q.rate_select_low}),
    .wave_q     (wave),
    .sec_tick_q (sec_tick)
  );

  // control register, power-on value 38h
  // stored fields and defaults
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ctrl_q <= rtc_pkg::rtc_ctrl_type'(rtc_pkg::CTRL_RESET);
    end else if (ctrl_wr) begin
      ctrl_q       <= rtc_pkg::rtc_ctrl_type'(reg_req.wdata);
      ctrl_q.zero6 <= 1'b0;
    end else if (cal_wr) begin
      ctrl_q.hold_to_set_flag <= 1'b1; // visible hold bit follows calendar writes
    end
  end

  // hold flag copy kept alongside for the calendar
  // calendar write forces hold
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cal_hold_q <= 1'b1;
    end else if (cal_wr) begin
      cal_hold_q <= 1'b1;
    end else if (ctrl_wr) begin
      cal_hold_q <= reg_req.wdata[rtc_pkg::HOLD_BIT];
    end
  end

  // start pulse clears calendar and prescaler
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cal_clear_q <= 1'b0;
    end else begin
      cal_clear_q <= start_req && !cal_wr;
    end
  end

  // seconds reach the calendar only while not held
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cal_tick_q <= 1'b0;
    end else begin
      cal_tick_q <= sec_tick && !cal_hold_q && !cal_wr;
    end
  end

  // match inputs sampled on the calendar tick only
  assign a1_set = cal_tick_q && evt.alarm1_match;
  assign a2_set = cal_tick_q && evt.alarm2_match;

  // status flags, set wins over a clearing write
  // sticky flags, cleared by writing zero
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      stat_q <= rtc_pkg::rtc_stat_type'(rtc_pkg::STAT_RESET);
    end else begin
      stat_q.zero6_3 <= 4'h0;
      stat_q.osc_halt_flag <= halt_s2_q || (stat_q.osc_halt_flag &&
                              !(stat_wr && !reg_req.wdata[rtc_pkg::OSF_BIT]));
      stat_q.bad_time_input_flag <= evt.bad_time || (stat_q.bad_time_input_flag &&
                              !(stat_wr && !reg_req.wdata[rtc_pkg::BAD_BIT]));
      stat_q.alarm2_match_flag <= a2_set || (stat_q.alarm2_match_flag &&
                              !(stat_wr && !reg_req.wdata[rtc_pkg::A2F_BIT]));
      stat_q.alarm1_match_flag <= a1_set || (stat_q.alarm1_match_flag &&
                              !(stat_wr && !reg_req.wdata[rtc_pkg::A1F_BIT]));
    end
  end

  // alarm 1 has priority when both are enabled
  always_comb begin
    if (ctrl_q.alarm1_irq_enable) begin
      alarm_on = stat_q.alarm1_match_flag;
    end else if (ctrl_q.alarm2_irq_enable) begin
      alarm_on = stat_q.alarm2_match_flag;
    end else begin
      alarm_on = 1'b0;
    end
  end

  // secondary alarm pin while the shared pin carries the wave
  assign alarm_irq_out_on = (ctrl_q.alarm1_irq_enable && stat_q.alarm1_match_flag) ||
                   (ctrl_q.alarm2_irq_enable && stat_q.alarm2_match_flag);

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wave_or_irq_out <= 1'b1;
      alarm_irq_out_n <= 1'b1;
    end else if (ctrl_q.irq_route_select) begin
      wave_or_irq_out <= !(alarm_on && !stat_q.bad_time_input_flag);
      alarm_irq_out_n <= 1'b1;
    end else begin
      wave_or_irq_out <= wave;
      alarm_irq_out_n <= !(alarm_irq_out_on && !stat_q.bad_time_input_flag);
    end
  end

  // registered read data
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= rd_mux(reg_req.addr, ctrl_q, stat_q);
    end
  end

  // scratch bit takes the written value
  a_free_bit_store: assert property (@(posedge clk) disable iff (!rst_sync_n)
    ctrl_wr |=> ctrl_q.free_bit == $past(wr_free))
    else $error("scratch bit did not store the written value");

  // calendar write raises hold on the next edge
  a_hold_on_calwr: assert property (@(posedge clk) disable iff (!rst_sync_n)
    cal_wr |=> cal_hold_q)
    else $error("hold flag not set after calendar write");

  // no calendar tick while held
  a_cal_stopped: assert property (@(posedge clk) disable iff (!rst_sync_n)
    cal_hold_q |=> !cal_tick_q)
    else $error("calendar ticked while held");

  // start request gives exactly one clear pulse
  a_start_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (start_req && !cal_wr) |=> cal_clear_q ##1 !cal_clear_q)
    else $error("start did not give one clear pulse");

  // wave routed when routing bit is zero
  a_wave_routed: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (rst_sync_n && !ctrl_q.irq_route_select) |=> wave_or_irq_out == $past(wave))
    else $error("square wave not on shared pin");

  // enabled alarm 1 pulls the pin low
  a_alarm1_low: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (ctrl_q.irq_route_select && ctrl_q.alarm1_irq_enable &&
     stat_q.alarm1_match_flag && !stat_q.bad_time_input_flag) |=> !wave_or_irq_out)
    else $error("alarm 1 did not drive shared pin low");

  // no enables, no interrupt
  a_enable_gate: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (ctrl_q.irq_route_select && !ctrl_q.alarm1_irq_enable &&
     !ctrl_q.alarm2_irq_enable) |=> wave_or_irq_out)
    else $error("interrupt raised with alarms disabled");

  // bad time input holds off the interrupt
  a_bad_suppress: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (ctrl_q.irq_route_select && stat_q.bad_time_input_flag) |=> wave_or_irq_out)
    else $error("interrupt raised while bad time flag set");

  // halt flag holds until a clearing write
  a_osf_sticky: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (stat_q.osc_halt_flag && !stat_wr) |=> stat_q.osc_halt_flag)
    else $error("oscillator halt flag dropped without a write");

  // alarm 1 flag rises only on a tick
  a_alarm_on_tick: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (!cal_tick_q && !stat_q.alarm1_match_flag) |=> !stat_q.alarm1_match_flag)
    else $error("alarm 1 flag set outside the seconds tick");

  // writing one leaves alarm 2 flag alone
  a_a2f_write_one: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (stat_wr && reg_req.wdata[rtc_pkg::A2F_BIT] && !stat_q.alarm2_match_flag && !a2_set)
    |=> !stat_q.alarm2_match_flag)
    else $error("alarm 2 flag set by a write");

endmodule : rtc_ctrl_stat
`default_nettype wire

// >>> include/rtc_pkg.sv
// constants and carrier types of the control and status register block
package rtc_pkg;

  // register offsets on the internal register port
  localparam logic [7:0] CTRL_ADDR     = 8'h0e;
  localparam logic [7:0] STAT_ADDR     = 8'h0f;
  localparam logic [7:0] CAL_LAST_ADDR = 8'h06;

  // power-on values
  localparam logic [7:0] CTRL_RESET = 8'h38;
  localparam logic [7:0] STAT_RESET = 8'h80;

  // bit positions inside the write data byte
  localparam int unsigned FREE_BIT = 7;
  localparam int unsigned HOLD_BIT = 5;
  localparam int unsigned OSF_BIT  = 7;
  localparam int unsigned BAD_BIT  = 2;
  localparam int unsigned A2F_BIT  = 1;
  localparam int unsigned A1F_BIT  = 0;

  // square-wave rate codes
  localparam logic [1:0] RATE_1HZ  = 2'h0;
  localparam logic [1:0] RATE_4K   = 2'h1;
  localparam logic [1:0] RATE_8K   = 2'h2;
  localparam logic [1:0] RATE_32K  = 2'h3;

  // oscillator divider: 15 stages from 32768 Hz down to 1 Hz
  localparam int unsigned DIV_BITS = 15;
  localparam int unsigned TAP_8K   = 1;
  localparam int unsigned TAP_4K   = 2;

  // control register layout
  typedef struct packed {
    logic       free_bit;
    logic       zero6;
    logic       hold_to_set_flag;
    logic       rate_select_high;
    logic       rate_select_low;
    logic       irq_route_select;
    logic       alarm2_irq_enable;
    logic       alarm1_irq_enable;
  } rtc_ctrl_type;

  // status register layout
  typedef struct packed {
    logic       osc_halt_flag;
    logic [3:0] zero6_3;
    logic       bad_time_input_flag;
    logic       alarm2_match_flag;
    logic       alarm1_match_flag;
  } rtc_stat_type;

  // one register access from the serial slave engine
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtc_req_type;

  // events from the calendar and analog side
  typedef struct packed {
    logic       bad_time;
    logic       alarm1_match;
    logic       alarm2_match;
  } rtc_evt_type;

endpackage : rtc_pkg

// >>> rtl/rtc_wave_div.sv
// oscillator edge counter giving square-wave taps and the one-second tick
`timescale 1ns/100ps
`default_nettype none
module rtc_wave_div #(
  parameter int unsigned DIV_BITS = rtc_pkg::DIV_BITS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       osc_lvl,
  input  wire logic       clear,
  input  wire logic [1:0] rate,
  output var  logic       wave_q,
  output var  logic       sec_tick_q
);

  logic                osc_prev_q;
  logic [DIV_BITS-1:0] cnt_q;
  logic                rise;

  initial begin
    if (DIV_BITS <= rtc_pkg::TAP_4K) begin
      $error("divider too short for the square-wave taps");
    end
  end

  assign rise = osc_lvl & ~osc_prev_q;

  // oscillator edge detect
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_lvl;
    end
  end

  // prescaler, restarted when timekeeping starts
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clear) begin
      cnt_q <= '0;
    end else if (rise) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // one pulse each time the prescaler wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= rise & (&cnt_q) & ~clear;
    end
  end

  // rate mux
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_q <= 1'b0;
    end else begin
      unique case (rate)
        rtc_pkg::RATE_1HZ: wave_q <= cnt_q[DIV_BITS-1];
        rtc_pkg::RATE_4K:  wave_q <= cnt_q[rtc_pkg::TAP_4K];
        rtc_pkg::RATE_8K:  wave_q <= cnt_q[rtc_pkg::TAP_8K];
        rtc_pkg::RATE_32K: wave_q <= osc_lvl;
      endcase
    end
  end

endmodule : rtc_wave_div
`default_nettype wire

// >>> dv/rtc_host_model.sv
// register-access host standing in for the serial slave engine
`timescale 1ns/100ps
`default_nettype none
module rtc_host_model (
  input  wire logic           clk,
  input  wire logic [7:0]     rd_data_q,
  output var  rtc_pkg::rtc_req_type req
);
  // idle port at time zero
  initial begin
    req = '0;
  end
  // one-cycle write strobe; data turned over once released
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(negedge clk);
    req.wr    = 1'b0;
    req.wdata = ~d;
  endtask : write_reg
  // pointer presented, byte taken one cycle later
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req.addr = a;
    @(negedge clk);
    d = rd_data_q;
  endtask : read_reg
  task automatic start_clock(input logic [7:0] c);
    write_reg(8'h0e, c & 8'hdf);
  endtask : start_clock
endmodule : rtc_host_model
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the control and status register block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] wa;
    logic [7:0] wd;
    logic [7:0] ra;
    logic [7:0] ex;
  } rtc_row_type;
  localparam rtc_row_type ROWS [5] = '{
    '{8'h0e, 8'hff, 8'h0e, 8'hbf}, '{8'h0e, 8'h80, 8'h0e, 8'h80},
    '{8'h03, 8'h12, 8'h0e, 8'ha0}, '{8'h0f, 8'h7f, 8'h0f, 8'h00},
    '{8'h12, 8'hff, 8'h12, 8'h00}};
  localparam int WAVE_EDGES [4] = '{0, 16, 32, 128};
  logic                 clk;
  logic                 rst_n;
  logic                 osc_pin;
  logic                 osc_halt_pin;
  rtc_pkg::rtc_req_type reg_req;
  rtc_pkg::rtc_evt_type evt;
  logic [7:0]           rd_data_q;
  logic                 wave_or_irq_out;
  logic                 alarm_irq_out_n;
  logic                 cal_tick_q;
  logic                 cal_clear_q;
  logic                 cal_hold_q;
  logic [7:0]           rd;
  int                   n_errors;
  int                   compares;
  int                   edges;

  rtc_ctrl_stat rtc_ctrl_stat_inst (
    .clk             (clk),
    .rst_n           (rst_n),
    .reg_req         (reg_req),
    .evt             (evt),
    .osc_pin         (osc_pin),
    .osc_halt_pin    (osc_halt_pin),
    .rd_data_q       (rd_data_q),
    .wave_or_irq_out (wave_or_irq_out),
    .alarm_irq_out_n (alarm_irq_out_n),
    .cal_tick_q      (cal_tick_q),
    .cal_clear_q     (cal_clear_q),
    .cal_hold_q      (cal_hold_q)
  );
  rtc_host_model rtc_host_model_inst (
    .clk       (clk),
    .rd_data_q (rd_data_q),
    .req       (reg_req)
  );

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // fast oscillator: one level change each cycle
  always @(negedge clk) begin
    osc_pin <= ~osc_pin;
  end
  // square-wave rising edges
  always @(posedge wave_or_irq_out) begin
    edges++;
  end
  // hang guard
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    results();
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rtc_host_model_inst.read_reg(a, rd);
    check(rd, exp);
  endtask : rd_chk
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : do_reset
  task automatic pulse_bad;
    @(negedge clk);
    evt.bad_time = 1'b1;
    @(negedge clk);
    evt.bad_time = 1'b0;
    repeat (2) @(negedge clk);
  endtask : pulse_bad
  task automatic results;
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // main sequence
  initial begin
    rst_n        = 1'b0;
    osc_pin      = 1'b0;
    osc_halt_pin = 1'b0;
    evt          = '0;
    n_errors     = 0;
    compares     = 0;
    do_reset();
    rd_chk(8'h0e, 8'h38);
    rd_chk(8'h0f, 8'h80);
    check({7'h0, cal_hold_q}, 8'h01);
    // each rate on the shared pin, calendar still held
    for (int r = 3; r >= 0; r--) begin
      rtc_host_model_inst.write_reg(8'h0e, 8'h20 | (8'(r) << 3));
      repeat (8) @(negedge clk);
      edges = 0;
      repeat (256) @(negedge clk);
      check({7'h0, edges >= WAVE_EDGES[r] - 1 && edges <= WAVE_EDGES[r] + 1}, 8'h01);
    end
    for (int i = 0; i < 5; i++) begin
      rtc_host_model_inst.write_reg(ROWS[i].wa, ROWS[i].wd);
      rd_chk(ROWS[i].ra, ROWS[i].ex);
    end
    // matches stand before the start but land only on the tick
    evt.alarm1_match = 1'b1;
    evt.alarm2_match = 1'b1;
    rtc_host_model_inst.start_clock(8'h05);
    check({7'h0, cal_hold_q}, 8'h00);
    check({7'h0, cal_clear_q}, 8'h01);
    @(negedge clk);
    check({7'h0, cal_clear_q}, 8'h00);
    repeat (19) @(negedge clk);
    rd_chk(8'h0f, 8'h00);
    for (int i = 0; i < 70000 && cal_tick_q !== 1'b1; i++) @(negedge clk);
    check({7'h0, cal_tick_q}, 8'h01);
    repeat (3) @(negedge clk);
    rd_chk(8'h0f, 8'h03);
    check({7'h0, wave_or_irq_out}, 8'h00);
    rtc_host_model_inst.write_reg(8'h0f, 8'hfe);
    rd_chk(8'h0f, 8'h02);
    check({7'h0, wave_or_irq_out}, 8'h01);
    rtc_host_model_inst.write_reg(8'h0e, 8'h06);
    repeat (2) @(negedge clk);
    check({7'h0, wave_or_irq_out}, 8'h00);
    pulse_bad();
    rd_chk(8'h0f, 8'h06);
    check({7'h0, wave_or_irq_out}, 8'h01);
    rtc_host_model_inst.write_reg(8'h0f, 8'h02);
    rd_chk(8'h0f, 8'h02);
    rtc_host_model_inst.write_reg(8'h0e, 8'h02);
    repeat (2) @(negedge clk);
    check({7'h0, alarm_irq_out_n}, 8'h00);
    rtc_host_model_inst.write_reg(8'h0e, 8'h00);
    repeat (2) @(negedge clk);
    check({7'h0, alarm_irq_out_n}, 8'h01);
    // halt pulse leaves a sticky flag
    @(negedge clk);
    osc_halt_pin = 1'b1;
    repeat (4) @(negedge clk);
    osc_halt_pin = 1'b0;
    repeat (4) @(negedge clk);
    rd_chk(8'h0f, 8'h82);
    // second reset in mid-run
    do_reset();
    rd_chk(8'h0e, 8'h38);
    rd_chk(8'h0f, 8'h80);
    results();
  end
endmodule : testbench
`default_nettype wire
